/* File: logic/fuh_pkg.sv */
`default_nettype none
package fuh_pkg;
  // ==========================================================
  // Device register map (holding-register numbers)
  localparam logic [15:0] REG_FW_VERSION  = 16'h0004;
  localparam logic [15:0] REG_NODE_ID     = 16'h0006;
  localparam logic [15:0] REG_UPDATE_STEP = 16'h0010;
  localparam logic [15:0] REG_LOC_PTR     = 16'h0011;
  // ==========================================================
  // Update step codes
  localparam logic [15:0] STEP_INIT   = 16'h007F;
  localparam logic [15:0] STEP_ERASE  = 16'h003F;
  localparam logic [15:0] STEP_PROG   = 16'h001F;
  localparam logic [15:0] STEP_NORMAL = 16'h0001;
  // ==========================================================
  // Bus function codes and hex record fields
  localparam logic [7:0] FN_READ    = 8'h03;
  localparam logic [7:0] FN_WRITE1  = 8'h06;
  localparam logic [7:0] FN_WRITEN  = 8'h10;
  localparam logic [7:0] REC_DATA   = 8'h00;
  localparam logic [7:0] REC_EOF    = 8'h01;
  localparam logic [7:0] MAX_BYTES  = 8'h80;
  localparam logic [7:0] BOOT_MARK  = 8'hFF;
  localparam logic [15:0] BOOT_ADDR = 16'h0000;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned RESET_WAIT_MS  = 250;
  localparam int unsigned ERASE_WAIT_MS  = 500;
  localparam int unsigned REPLY_WAIT_MS  = 20;
  localparam int unsigned RESET_WAIT_CYC = RESET_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned ERASE_WAIT_CYC = ERASE_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned REPLY_WAIT_CYC = REPLY_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W        = 23;
  localparam int unsigned MAX_TRIES      = 4;
  // ==========================================================
  // Software register word indices
  localparam logic [2:0] AV_CTRL    = 3'h0;
  localparam logic [2:0] AV_STATUS  = 3'h1;
  localparam logic [2:0] AV_REC_HDR = 3'h2;
  localparam logic [2:0] AV_REC_BYT = 3'h3;
  localparam logic [2:0] AV_REC_SUM = 3'h4;
  localparam logic [2:0] AV_PTR     = 3'h5;
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_RESUME_BIT = 1;
  // ==========================================================
  // Sequencer step and phase types, and link carriers
  typedef enum logic [3:0] {
    ST_IDLE, ST_INIT1, ST_INIT2, ST_ERASE, ST_START, ST_RDSTEP,
    ST_RDPTR, ST_RECWAIT, ST_RECDATA, ST_FINISH, ST_DONE, ST_ERR
  } fuh_step_t;
  typedef enum logic [1:0] {PH_ISSUE, PH_STREAM, PH_WAIT} fuh_phase_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] value;
    logic [7:0]  count;
  } fuh_req_t;
  typedef struct packed {
    logic        valid;
    logic        ok;
    logic [15:0] value;
  } fuh_rsp_t;
endpackage
`default_nettype wire

/* File: logic/fuh_update_host.sv */
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fuh_update_host #(
  parameter int unsigned RESET_CYC = fuh_pkg::RESET_WAIT_CYC,
  parameter int unsigned ERASE_CYC = fuh_pkg::ERASE_WAIT_CYC,
  parameter int unsigned REPLY_CYC = fuh_pkg::REPLY_WAIT_CYC
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [2:0]       avAddress,
  input  wire logic             avRead,
  input  wire logic             avWrite,
  input  wire logic [31:0]      avWritedata,
  output logic [31:0]           avReaddata,
  output logic                  avWaitrequest,
  output fuh_pkg::fuh_req_t     linkReq,
  input  wire logic             linkReqReady,
  output logic                  linkByteValid,
  output logic [7:0]            linkByte,
  input  wire logic             linkByteReady,
  input  wire fuh_pkg::fuh_rsp_t linkRsp
);
  localparam int unsigned TW = fuh_pkg::TIMER_W;

  typedef struct packed {
    fuh_pkg::fuh_step_t  step;
    fuh_pkg::fuh_phase_t phase;
    logic [TW-1:0]       timer;
    logic [3:0]          tries;
    logic [7:0]          idx;
    logic [7:0]          len;
    logic [15:0]         loadAddr;
    logic [7:0]          recType;
    logic [7:0]          sum;
    logic [127:0][7:0]   recBuf;
    logic [15:0]         ptr;
    logic                done;
    logic                err;
    logic                recBad;
    fuh_pkg::fuh_req_t   req;
    logic                byteValid;
    logic [7:0]          byteData;
    logic                waitReq;
    logic [31:0]         rdData;
  } fuh_state_t;

  fuh_state_t s_q;
  fuh_state_t s_d;
  logic [7:0] total;

  assign avReaddata    = s_q.rdData;
  assign avWaitrequest = s_q.waitReq;
  assign linkReq       = s_q.req;
  assign linkByteValid = s_q.byteValid;
  assign linkByte      = s_q.byteData;

  // ==========================================================
  // Reply window per step
  function automatic logic [TW-1:0] waitFor(input fuh_pkg::fuh_step_t st);
    case (st)
      fuh_pkg::ST_INIT1, fuh_pkg::ST_INIT2: waitFor = TW'(RESET_CYC);
      fuh_pkg::ST_ERASE:                    waitFor = TW'(ERASE_CYC);
      default:                              waitFor = TW'(REPLY_CYC);
    endcase
  endfunction

  // ==========================================================
  // Sequencer
  always_comb begin
    s_d = s_q;
    total = s_q.sum + avWritedata[7:0];
    case (s_q.phase)
      fuh_pkg::PH_ISSUE: begin
        if (s_q.step != fuh_pkg::ST_IDLE && s_q.step != fuh_pkg::ST_RECWAIT &&
            s_q.step != fuh_pkg::ST_DONE && s_q.step != fuh_pkg::ST_ERR) begin
          s_d.req.valid = 1'b1;
          s_d.req.func  = fuh_pkg::FN_WRITE1;
          s_d.req.addr  = fuh_pkg::REG_UPDATE_STEP;
          s_d.req.count = 8'h01;
          case (s_q.step)
            fuh_pkg::ST_INIT1, fuh_pkg::ST_INIT2: s_d.req.value = fuh_pkg::STEP_INIT;
            fuh_pkg::ST_ERASE:  s_d.req.value = fuh_pkg::STEP_ERASE;
            fuh_pkg::ST_START:  s_d.req.value = fuh_pkg::STEP_PROG;
            fuh_pkg::ST_FINISH: s_d.req.value = fuh_pkg::STEP_NORMAL;
            fuh_pkg::ST_RDSTEP: s_d.req.func  = fuh_pkg::FN_READ;
            fuh_pkg::ST_RDPTR: begin
              s_d.req.func = fuh_pkg::FN_READ;
              s_d.req.addr = fuh_pkg::REG_LOC_PTR;
            end
            fuh_pkg::ST_RECDATA: begin
              s_d.req.func  = fuh_pkg::FN_WRITEN;
              s_d.req.addr  = s_q.loadAddr;
              s_d.req.count = s_q.len;
            end
            default: s_d.req.value = s_q.req.value;
          endcase
          if (s_q.req.valid && linkReqReady) begin
            s_d.req.valid = 1'b0;
            s_d.idx = 8'h00;
            if (s_q.step == fuh_pkg::ST_RECDATA) begin
              s_d.phase = fuh_pkg::PH_STREAM;
            end else begin
              s_d.phase = fuh_pkg::PH_WAIT;
              s_d.timer = waitFor(s_q.step);
            end
          end
        end
      end
      fuh_pkg::PH_STREAM: begin
        if (!s_q.byteValid || linkByteReady) begin
          if (s_q.idx < s_q.len) begin
            s_d.byteValid = 1'b1;
            // Flash byte 0000h must stay FF so the part can always re-enter boot mode
            if (s_q.loadAddr + 16'(s_q.idx) == fuh_pkg::BOOT_ADDR) begin
              s_d.byteData = fuh_pkg::BOOT_MARK;
            end else begin
              s_d.byteData = s_q.recBuf[s_q.idx[6:0]];
            end
            s_d.idx = s_q.idx + 8'h01;
          end else begin
            s_d.byteValid = 1'b0;
            s_d.phase = fuh_pkg::PH_WAIT;
            s_d.timer = waitFor(s_q.step);
          end
        end
      end
      fuh_pkg::PH_WAIT: begin
        if (s_q.step == fuh_pkg::ST_INIT1) begin
          // No reply follows the first init write; just let the reset run out
          if (s_q.timer == '0) begin
            s_d.step  = fuh_pkg::ST_INIT2;
            s_d.phase = fuh_pkg::PH_ISSUE;
            s_d.tries = 4'h0;
          end else begin
            s_d.timer = s_q.timer - TW'(1);
          end
        end else if (linkRsp.valid && linkRsp.ok) begin
          s_d.phase = fuh_pkg::PH_ISSUE;
          s_d.tries = 4'h0;
          case (s_q.step)
            fuh_pkg::ST_INIT2:   s_d.step = fuh_pkg::ST_ERASE;
            fuh_pkg::ST_ERASE:   s_d.step = fuh_pkg::ST_START;
            fuh_pkg::ST_START:   s_d.step = fuh_pkg::ST_RECWAIT;
            fuh_pkg::ST_RECDATA: s_d.step = fuh_pkg::ST_RECWAIT;
            fuh_pkg::ST_RDPTR: begin
              s_d.ptr  = linkRsp.value;
              s_d.step = fuh_pkg::ST_START;
            end
            fuh_pkg::ST_RDSTEP: begin
              if (linkRsp.value == fuh_pkg::STEP_ERASE) begin
                s_d.step = fuh_pkg::ST_ERASE;
              end else if (linkRsp.value == fuh_pkg::STEP_PROG) begin
                s_d.step = fuh_pkg::ST_RDPTR;
              end else begin
                s_d.step = fuh_pkg::ST_ERR;
                s_d.err  = 1'b1;
              end
            end
            default: begin
              s_d.step = fuh_pkg::ST_DONE;
              s_d.done = 1'b1;
            end
          endcase
        end else if (s_q.timer == '0 || linkRsp.valid) begin
          if (s_q.step == fuh_pkg::ST_FINISH) begin
            // The device may reboot before answering the final step
            s_d.step = fuh_pkg::ST_DONE;
            s_d.done = 1'b1;
          end else if (s_q.tries == 4'(fuh_pkg::MAX_TRIES - 1)) begin
            s_d.step = fuh_pkg::ST_ERR;
            s_d.err  = 1'b1;
          end else begin
            s_d.tries = s_q.tries + 4'h1;
          end
          s_d.phase = fuh_pkg::PH_ISSUE;
        end else begin
          s_d.timer = s_q.timer - TW'(1);
        end
      end
      default: s_d.phase = fuh_pkg::PH_ISSUE;
    endcase

    // ========================================================
    // Avalon-MM slave: every access answered one cycle after it starts
    s_d.waitReq = 1'b1;
    if ((avRead || avWrite) && s_q.waitReq) begin
      s_d.waitReq = 1'b0;
      case (avAddress)
        fuh_pkg::AV_CTRL:   s_d.rdData = {28'h0000000, s_q.step};
        fuh_pkg::AV_STATUS: s_d.rdData = {16'h0000, s_q.tries, 4'h0, s_q.recBad, s_q.err,
                                          s_q.done, s_q.step == fuh_pkg::ST_RECWAIT,
                                          s_q.phase, 2'h0};
        fuh_pkg::AV_PTR:    s_d.rdData = {16'h0000, s_q.ptr};
        default:            s_d.rdData = 32'h00000000;
      endcase
    end
    if (avWrite && !s_q.waitReq) begin
      case (avAddress)
        fuh_pkg::AV_CTRL: begin
          if (s_q.step == fuh_pkg::ST_IDLE || s_q.step == fuh_pkg::ST_DONE ||
              s_q.step == fuh_pkg::ST_ERR) begin
            s_d.done  = 1'b0;
            s_d.err   = 1'b0;
            s_d.tries = 4'h0;
            s_d.phase = fuh_pkg::PH_ISSUE;
            if (avWritedata[fuh_pkg::CTRL_START_BIT]) begin
              s_d.step = fuh_pkg::ST_INIT1;
            end else if (avWritedata[fuh_pkg::CTRL_RESUME_BIT]) begin
              s_d.step = fuh_pkg::ST_RDSTEP;
            end
          end
        end
        fuh_pkg::AV_REC_HDR: begin
          if (s_q.step == fuh_pkg::ST_RECWAIT) begin
            s_d.len      = avWritedata[7:0];
            s_d.loadAddr = avWritedata[23:8];
            s_d.recType  = avWritedata[31:24];
            s_d.sum      = avWritedata[7:0] + avWritedata[15:8] + avWritedata[23:16] +
                           avWritedata[31:24];
            s_d.idx      = 8'h00;
            s_d.recBad   = 1'b0;
          end
        end
        fuh_pkg::AV_REC_BYT: begin
          if (s_q.step == fuh_pkg::ST_RECWAIT && s_q.idx < fuh_pkg::MAX_BYTES) begin
            s_d.recBuf[s_q.idx[6:0]] = avWritedata[7:0];
            s_d.sum = s_q.sum + avWritedata[7:0];
            s_d.idx = s_q.idx + 8'h01;
          end
        end
        fuh_pkg::AV_REC_SUM: begin
          if (s_q.step == fuh_pkg::ST_RECWAIT) begin
            if (total != 8'h00) begin
              s_d.recBad = 1'b1;
            end else if (s_q.recType == fuh_pkg::REC_EOF) begin
              s_d.step = fuh_pkg::ST_FINISH;
            end else if (s_q.recType == fuh_pkg::REC_DATA) begin
              if (s_q.len == 8'h00 || s_q.len > fuh_pkg::MAX_BYTES || s_q.idx != s_q.len) begin
                s_d.recBad = 1'b1;
              end else begin
                s_d.step  = fuh_pkg::ST_RECDATA;
                s_d.tries = 4'h0;
              end
            end
          end
        end
        default: s_d.done = s_q.done;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q         <= '0;
      s_q.step    <= fuh_pkg::ST_IDLE;
      s_q.phase   <= fuh_pkg::PH_ISSUE;
      s_q.waitReq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seqInitIssued;
    s_q.step == fuh_pkg::ST_INIT1 && s_q.req.valid && linkReqReady;
  endsequence
  sequence seqRecLaunch;
    avWrite && !s_q.waitReq && avAddress == fuh_pkg::AV_REC_SUM &&
      s_q.step == fuh_pkg::ST_RECWAIT;
  endsequence

  chk_init_code: assert property (seqInitIssued |-> s_q.req.value == fuh_pkg::STEP_INIT)
    else $error("init write does not carry 7Fh");
  chk_init_silent: assert property (seqInitIssued |=> s_q.step == fuh_pkg::ST_INIT1
      && s_q.phase == fuh_pkg::PH_WAIT && s_q.timer == TW'(RESET_CYC))
    else $error("first init write not followed by reset wait");
  chk_init_repeat: assert property ($rose(s_q.step == fuh_pkg::ST_INIT2) |->
      $past(s_q.step) == fuh_pkg::ST_INIT1 && $past(s_q.timer) == '0)
    else $error("init repeated before the reset wait ran out");
  chk_erase_code: assert property (s_q.req.valid && s_q.step == fuh_pkg::ST_ERASE |->
      s_q.req.value == fuh_pkg::STEP_ERASE)
    else $error("erase write does not carry 3Fh");
  chk_erase_window: assert property (s_q.step == fuh_pkg::ST_ERASE && s_q.req.valid &&
      linkReqReady |=> s_q.timer == TW'(ERASE_CYC))
    else $error("erase reply window wrong");
  chk_prog_code: assert property (s_q.req.valid && s_q.step == fuh_pkg::ST_START |->
      s_q.req.value == fuh_pkg::STEP_PROG && s_q.req.addr == fuh_pkg::REG_UPDATE_STEP)
    else $error("programming write does not carry 1Fh");
  chk_bad_record: assert property (seqRecLaunch ##0 total != 8'h00 |=>
      s_q.recBad && s_q.step == fuh_pkg::ST_RECWAIT)
    else $error("record with bad checksum was sent");
  chk_record_len: assert property (s_q.req.valid &&
      s_q.req.func == fuh_pkg::FN_WRITEN |->
      s_q.req.count != 8'h00 && s_q.req.count <= fuh_pkg::MAX_BYTES &&
      s_q.req.addr == s_q.loadAddr)
    else $error("multiple write length or address wrong");
  chk_zero_addr: assert property (s_q.phase == fuh_pkg::PH_STREAM && s_q.byteValid &&
      s_q.loadAddr + 16'(s_q.idx) == fuh_pkg::BOOT_ADDR + 16'h0001 |->
      s_q.byteData == fuh_pkg::BOOT_MARK)
    else $error("byte for flash 0000h is not FF");
  chk_resend: assert property (s_q.step == fuh_pkg::ST_RECDATA && s_q.phase ==
      fuh_pkg::PH_WAIT && s_q.timer == '0 && !linkRsp.valid && s_q.tries < 4'h3 |=>
      s_q.phase == fuh_pkg::PH_ISSUE ##1 s_q.req.valid)
    else $error("record not resent after reply timeout");
  chk_finish_code: assert property (s_q.req.valid && s_q.step == fuh_pkg::ST_FINISH |->
      s_q.req.value == fuh_pkg::STEP_NORMAL)
    else $error("final write does not carry 01h");
  chk_bus_answer: assert property ((avRead || avWrite) && s_q.waitReq |=> !s_q.waitReq
      ##1 s_q.waitReq)
    else $error("bus access not answered in one cycle");
endmodule
`default_nettype wire

/* File: verification/fuh_device_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fuh_device_model (
  input  wire logic              clk,
  input  wire fuh_pkg::fuh_req_t linkReq,
  output logic                   linkReqReady,
  input  wire logic              linkByteValid,
  input  wire logic [7:0]        linkByte,
  output logic                   linkByteReady,
  output fuh_pkg::fuh_rsp_t      linkRsp,
  input  wire logic [7:0]        dropAt
);
  // Arbitrary build number
  localparam logic [15:0] FW_VER = 16'h0A01;
  logic [7:0]  flash [0:65535];
  logic [15:0] stepReg  = 16'h0001;
  logic [15:0] nodeReg  = 16'h0011;
  logic [15:0] ptrReg   = 16'h0000;
  logic [15:0] wrAddr   = 16'h0000;
  logic [15:0] rspVal   = 16'h0000;
  logic [7:0]  left     = 8'h00;
  logic [7:0]  waitCnt  = 8'h00;
  logic        bootMode = 1'b0;
  logic        pend     = 1'b0;
  logic        dropHit  = 1'b0;
  int          erases   = 0;
  int          initWrites = 0;
  int          multiCnt = 0;
  // ==========================================================
  // Register file, kept across host resets
  function automatic logic [15:0] rd(input logic [15:0] a);
    case (a)
      fuh_pkg::REG_FW_VERSION:  return FW_VER;
      fuh_pkg::REG_NODE_ID:     return nodeReg;
      fuh_pkg::REG_UPDATE_STEP: return stepReg;
      fuh_pkg::REG_LOC_PTR:     return ptrReg;
      default:                  return 16'h0000;
    endcase
  endfunction
  task automatic reply(input logic [15:0] v, input logic [7:0] d);
    rspVal  <= v;
    waitCnt <= d;
    pend    <= 1'b1;
  endtask
  initial begin
    for (int i = 0; i < 65536; i++)
      flash[i] = 8'hFF;
    linkReqReady  = 1'b0;
    linkByteReady = 1'b0;
    linkRsp       = '0;
  end
  // ==========================================================
  // Link side; idle reply value toggles so stale data never matches
  always @(posedge clk) begin
    linkReqReady  <= 1'b0;
    // Ready drops every other cycle to stall the byte stream
    linkByteReady <= ~linkByteReady & (left != 8'h00);
    linkRsp       <= '{1'b0, 1'b1, ~linkRsp.value};
    if (pend && waitCnt != 8'h00)
      waitCnt <= waitCnt - 8'h01;
    if (pend && waitCnt == 8'h00) begin
      pend    <= 1'b0;
      linkRsp <= '{1'b1, 1'b1, rspVal};
    end
    if (linkByteValid && linkByteReady && left != 8'h00) begin
      if (stepReg == fuh_pkg::STEP_PROG) begin
        flash[wrAddr] <= linkByte;
        ptrReg        <= wrAddr + 16'h0001;
      end
      wrAddr <= wrAddr + 16'h0001;
      left   <= left - 8'h01;
      if (left == 8'h01 && !dropHit)
        reply(16'h0000, 8'h0A);
    end
    if (linkReq.valid && !linkReqReady && !pend && left == 8'h00) begin
      linkReqReady <= 1'b1;
      case (linkReq.func)
        fuh_pkg::FN_WRITEN: begin
          wrAddr   <= linkReq.addr;
          left     <= linkReq.count;
          multiCnt <= multiCnt + 1;
          dropHit  <= (multiCnt + 1 == int'(dropAt));
        end
        fuh_pkg::FN_READ: reply(rd(linkReq.addr), 8'h05);
        default: begin
          if (linkReq.addr == fuh_pkg::REG_NODE_ID) begin
            nodeReg <= linkReq.value;
            reply(linkReq.value, 8'h0A);
          end else if (linkReq.addr == fuh_pkg::REG_UPDATE_STEP) begin
            stepReg <= linkReq.value;
            case (linkReq.value)
              fuh_pkg::STEP_INIT: begin
                initWrites <= initWrites + 1;
                if (bootMode)
                  reply(linkReq.value, 8'h28);
                else
                  bootMode <= (flash[0] == fuh_pkg::BOOT_MARK);
              end
              fuh_pkg::STEP_ERASE: begin
                erases <= erases + 1;
                for (int i = 0; i < 65536; i++)
                  flash[i] <= 8'hFF;
                reply(linkReq.value, 8'h3C);
              end
              fuh_pkg::STEP_NORMAL: begin
                bootMode <= 1'b0;
                reply(linkReq.value, 8'h0A);
              end
              default: reply(linkReq.value, 8'h0A);
            endcase
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verification/test_firmware_update_handler.sv */
`timescale 1ns/10ps
`default_nettype none
module test_firmware_update_handler;
  logic              clk         = 1'b0;
  logic              rstn        = 1'b0;
  logic [2:0]        avAddress   = 3'h0;
  logic              avRead      = 1'b0;
  logic              avWrite     = 1'b0;
  logic [31:0]       avWritedata = 32'h0;
  logic [7:0]        dropAt      = 8'hFF;
  logic [31:0]       avReaddata;
  logic              avWaitrequest;
  fuh_pkg::fuh_req_t linkReq;
  fuh_pkg::fuh_rsp_t linkRsp;
  logic              linkReqReady;
  logic              linkByteValid;
  logic              linkByteReady;
  logic [7:0]        linkByte;
  logic [31:0]       rdData;
  logic [7:0]        recQ [$];
  int                error_cnt   = 0;
  int                n_compared  = 0;
  int                cyc         = 0;
  int                n;
  fuh_update_host #(.RESET_CYC(50), .ERASE_CYC(80), .REPLY_CYC(30)) dut (
    .clk(clk), .rstn(rstn), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWritedata(avWritedata), .avReaddata(avReaddata),
    .avWaitrequest(avWaitrequest), .linkReq(linkReq), .linkReqReady(linkReqReady),
    .linkByteValid(linkByteValid), .linkByte(linkByte),
    .linkByteReady(linkByteReady), .linkRsp(linkRsp));
  fuh_device_model dev (
    .clk(clk), .linkReq(linkReq), .linkReqReady(linkReqReady),
    .linkByteValid(linkByteValid), .linkByte(linkByte),
    .linkByteReady(linkByteReady), .linkRsp(linkRsp), .dropAt(dropAt));
  initial begin
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // Verdict and hang guard
  task automatic final_report;
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // ==========================================================
  // Avalon master: hold until waitrequest is sampled low
  task automatic av_rd(input logic [2:0] a, output logic [31:0] d);
    avAddress <= a;
    avRead    <= 1'b1;
    @(posedge clk);
    while (avWaitrequest !== 1'b0)
      @(posedge clk);
    d = avReaddata;
    avRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic av_wr(input logic [2:0] a, input logic [31:0] d);
    avAddress   <= a;
    avWritedata <= d;
    avWrite     <= 1'b1;
    @(posedge clk);
    while (avWaitrequest !== 1'b0)
      @(posedge clk);
    avWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_step(input logic [3:0] s);
    n = 0;
    do begin
      av_rd(fuh_pkg::AV_CTRL, rdData);
      n++;
    end while (rdData[3:0] !== s && n < 3000);
    check({28'h0, rdData[3:0]}, {28'h0, s}, "step");
  endtask
  task automatic send_rec(input logic [7:0] typ, input logic [15:0] a, input logic [7:0] bad);
    logic [7:0] s;
    s = 8'(recQ.size()) + a[15:8] + a[7:0] + typ;
    foreach (recQ[i])
      s = s + recQ[i];
    av_wr(fuh_pkg::AV_REC_HDR, {typ, a, 8'(recQ.size())});
    foreach (recQ[i])
      av_wr(fuh_pkg::AV_REC_BYT, {24'h0, recQ[i]});
    av_wr(fuh_pkg::AV_REC_SUM, {24'h0, (8'h00 - s) ^ bad});
  endtask
  task automatic rec_ok(input logic [15:0] a);
    send_rec(fuh_pkg::REC_DATA, a, 8'h00);
    wait_step(4'(fuh_pkg::ST_RECDATA));
    wait_step(4'(fuh_pkg::ST_RECWAIT));
  endtask
  task automatic pulse_reset;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    av_rd(fuh_pkg::AV_CTRL, rdData);
    check(rdData, 32'h0, "idle step");
    av_rd(3'h7, rdData);
    check(rdData, 32'h0, "unmapped");
    av_wr(fuh_pkg::AV_CTRL, 32'h1);
    wait_step(4'(fuh_pkg::ST_RECWAIT));
    check(32'(dev.initWrites), 32'h00000002, "init writes");
    check(32'(dev.erases), 32'h00000001, "erases");
    recQ = '{8'h02, 8'h02, 8'h00};
    rec_ok(16'h0000);
    check({8'h0, dev.flash[0], dev.flash[1], dev.flash[2]}, 32'h00FF0200, "low");
    recQ = '{8'hAA};
    send_rec(fuh_pkg::REC_DATA, 16'h0080, 8'h01);
    av_rd(fuh_pkg::AV_STATUS, rdData);
    check({31'h0, rdData[7]}, 32'h1, "reject");
    check({24'h0, dev.flash[128]}, 32'hFF, "no write");
    dropAt <= 8'h02;
    recQ = '{8'hAF, 8'h5F, 8'h67, 8'hF0, 8'h60, 8'h27, 8'h03, 8'hE0,
             8'h32, 8'h2C, 8'hFA, 8'h92, 8'h00, 8'h77, 8'h80, 8'hC3};
    rec_ok(16'h0080);
    check(32'(dev.multiCnt), 32'h00000003, "resend");
    check({16'h0, dev.flash[128], dev.flash[143]}, 32'hAFC3, "record");
    pulse_reset();
    check({16'h0, dev.stepReg}, 32'h1F, "kept step");
    av_wr(fuh_pkg::AV_CTRL, 32'h2);
    wait_step(4'(fuh_pkg::ST_RECWAIT));
    av_rd(fuh_pkg::AV_PTR, rdData);
    check({16'h0, rdData[15:0]}, 32'h0090, "pointer");
    recQ.delete();
    for (int i = 0; i < 128; i++)
      recQ.push_back(8'(i));
    rec_ok(16'h0100);
    check({16'h0, dev.ptrReg}, 32'h0180, "ptr");
    check({24'h0, dev.flash[16'h017F]}, 32'h7F, "last byte");
    recQ.delete();
    send_rec(fuh_pkg::REC_EOF, 16'h0000, 8'h00);
    wait_step(4'(fuh_pkg::ST_DONE));
    check({15'h0, dev.bootMode, dev.stepReg}, 32'h0001, "normal boot");
    av_rd(fuh_pkg::AV_STATUS, rdData);
    check({30'h0, rdData[6:5]}, 32'h1, "done flag");
    av_wr(fuh_pkg::AV_CTRL, 32'h1);
    n = 0;
    while (dev.erases != 2 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    pulse_reset();
    check({16'h0, dev.stepReg}, 32'h3F, "erase step");
    av_wr(fuh_pkg::AV_CTRL, 32'h2);
    wait_step(4'(fuh_pkg::ST_RECWAIT));
    check(32'(dev.erases), 32'h00000003, "erase again");
    check({24'h0, dev.flash[1]}, 32'hFF, "erased");
    final_report();
  end
endmodule
`default_nettype wire
